// ### logic/dicr_pkg.sv
// Constants, register map and types of the digital input conditioning router
package dicr_pkg;
   localparam int unsigned DICR_CLK_HZ = 250_000_000;
   localparam int unsigned DICR_SAMPLE_US = 1000;
   localparam int unsigned DICR_TICK_CYC = DICR_CLK_HZ / 1_000_000 * DICR_SAMPLE_US;
   localparam int unsigned DICR_NIN = 16;
   // Register byte offsets
   localparam logic [7:0] DICR_OFS_SFE = 8'h00;
   localparam logic [7:0] DICR_OFS_INV = 8'h04;
   localparam logic [7:0] DICR_OFS_FEN = 8'h08;
   localparam logic [7:0] DICR_OFS_FVAL = 8'h0C;
   localparam logic [7:0] DICR_OFS_RAW = 8'h10;
   localparam logic [7:0] DICR_OFS_THR = 8'h14;
   localparam logic [7:0] DICR_OFS_PAIR = 8'h18;
   localparam logic [7:0] DICR_OFS_REN = 8'h1C;
   localparam logic [7:0] DICR_OFS_SUM = 8'h20;
   localparam logic [7:0] DICR_OFS_STAT = 8'h24;
   localparam logic [7:0] DICR_OFS_TBL = 8'h80;
   // Special-function bit positions
   localparam int unsigned DICR_BIT_NLIM = 0;
   localparam int unsigned DICR_BIT_PLIM = 1;
   localparam int unsigned DICR_BIT_HOME = 2;
   localparam int unsigned DICR_BIT_ILCK = 3;
   localparam int unsigned DICR_LVL_BASE = 16;
   // Inputs carrying enable, direction and clock (zero based)
   localparam logic [15:0] DICR_CD_MASK = 16'h0030;
   localparam logic [15:0] DICR_CAP_MASK = 16'h0038;
   // Source codes
   localparam logic [7:0] DICR_SRC_ZERO = 8'h00;
   localparam logic [7:0] DICR_SRC_IN1 = 8'h01;
   localparam logic [7:0] DICR_SRC_IN16 = 8'h10;
   localparam logic [7:0] DICR_SRC_HALLU = 8'h41;
   localparam logic [7:0] DICR_SRC_USB = 8'h47;
   localparam logic [7:0] DICR_SRC_INV = 8'h80;
   // Reset values
   localparam logic [31:0] DICR_RST_WORD = 32'h0000_0000;
   localparam logic [7:0] DICR_RST_ENTRY = 8'h00;
   typedef enum logic [1:0] {
      DICR_NORMAL = 2'b00,
      DICR_PRELOAD = 2'b01,
      DICR_ROUTED = 2'b11
   } dicr_mode_t;
endpackage

// ### logic/dicr_top.sv
// Digital input conditioning router with APB register access
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dicr_top #(
   parameter int unsigned TICK_CYC = dicr_pkg::DICR_TICK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins and internal signal sources
   input wire logic [15:0] pin_in,
   input wire logic [2:0] hall_in,
   input wire logic [2:0] enc_in,
   input wire logic usb_power_in,
   // Conditioned results
   output logic [31:0] input_summary_word,
   output logic [15:0] cd_level,
   output logic neg_limit,
   output logic pos_limit,
   output logic home_sw,
   output logic interlock_fault,
   output logic threshold_24v,
   output logic pair_differential,
   output logic [15:0] neg_input_en
);
   import dicr_pkg::*;

   // ====================================================================
   // Reset release and input synchronisers
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   localparam int unsigned NSRC = 23;
   logic [NSRC-1:0] meta_q;
   logic [NSRC-1:0] sync_q;
   // First stage may go metastable; only the second stage is read by logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
      end else begin
         meta_q <= {usb_power_in, enc_in, hall_in, pin_in};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_q <= '0;
      end else begin
         sync_q <= meta_q;
      end
   end

   // ====================================================================
   // Millisecond sample tick
   logic [31:0] tick_cnt_q;
   logic tick_q;
   // Sample period counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= '0;
      end else if (tick_cnt_q == TICK_CYC - 1) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
   end

   // One-cycle sample enable; pin pulses that start and end between two enables are never seen
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == TICK_CYC - 1);
      end
   end

   // ====================================================================
   // Configuration registers
   logic [31:0] sfe_q;
   logic [31:0] inv_q;
   logic [31:0] fen_q;
   logic [31:0] fval_q;
   logic [31:0] thr_q;
   logic [31:0] pair_q;
   logic [31:0] ren_q;
   logic [31:0] raw_q;
   logic [31:0] sum_q;
   logic [7:0] tbl_q [0:31];
   dicr_mode_t mode_q;
   logic wr_en;
   logic rd_en;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   // Legal addresses: aligned, in the register block or the routing table
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a <= DICR_OFS_STAT) || (a >= DICR_OFS_TBL);
      if (a[1:0] != 2'b00) begin
         addr_ok = 1'b0;
      end
   endfunction

   // Conditioning settings, full 32-bit words
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfe_q <= DICR_RST_WORD;
         inv_q <= DICR_RST_WORD;
         fen_q <= DICR_RST_WORD;
         fval_q <= DICR_RST_WORD;
      end else if (wr_en) begin
         case (paddr)
            DICR_OFS_SFE: sfe_q <= pwdata;
            DICR_OFS_INV: inv_q <= pwdata;
            DICR_OFS_FEN: fen_q <= pwdata;
            DICR_OFS_FVAL: fval_q <= pwdata;
            default: begin
            end
         endcase
      end
   end

   // Electrical settings, one bit each for all capable inputs at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thr_q <= DICR_RST_WORD;
         pair_q <= DICR_RST_WORD;
      end else if (wr_en) begin
         case (paddr)
            DICR_OFS_THR: thr_q <= {31'h0, pwdata[0]};
            DICR_OFS_PAIR: pair_q <= {31'h0, pwdata[0]};
            default: begin
            end
         endcase
      end
   end

   // Routing enable; toggling it reloads the table, so software should set it once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ren_q <= DICR_RST_WORD;
      end else if (wr_en && paddr == DICR_OFS_REN) begin
         ren_q <= {31'h0, pwdata[0]};
      end
   end

   // ====================================================================
   // Routing mode sequencer and table
   dicr_mode_t mode_d;
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         DICR_NORMAL: begin
            if (ren_q[0]) begin
               mode_d = DICR_PRELOAD;
            end
         end
         DICR_PRELOAD: begin
            mode_d = ren_q[0] ? DICR_ROUTED : DICR_NORMAL;
         end
         DICR_ROUTED: begin
            if (!ren_q[0]) begin
               mode_d = DICR_NORMAL;
            end
         end
         default: begin
            mode_d = DICR_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= DICR_NORMAL;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Identity mapping: low bit k and level bit k+16 both take input k+1
   function automatic logic [7:0] ident_code(input int unsigned k);
      ident_code = (k < DICR_NIN) ? 8'(k + 1) : 8'(k - DICR_LVL_BASE + 1);
   endfunction

   // Preload takes priority over a table write in the same cycle
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_tbl
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               tbl_q[g] <= DICR_RST_ENTRY;
            end else if (mode_q == DICR_PRELOAD) begin
               tbl_q[g] <= ident_code(g);
            end else if (wr_en && paddr == 8'(DICR_OFS_TBL + 4 * g)) begin
               tbl_q[g] <= pwdata[7:0];
            end
         end
      end
   endgenerate

   // ====================================================================
   // Input computation: raw, force, invert, route, summary
   logic [15:0] cond;
   logic [31:0] norm_word;
   logic [31:0] route_word;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         raw_q <= DICR_RST_WORD;
      end else if (tick_q) begin
         raw_q <= {16'h0, sync_q[15:0]};
      end
   end

   // Per input: forcing first, then the contact logic; clock and direction bypass inversion
   logic [15:0] forced_lvl;
   logic [15:0] inv_eff;
   generate
      for (g = 0; g < DICR_NIN; g++) begin : g_cond
         assign forced_lvl[g] = fen_q[g] ? fval_q[g] : raw_q[g];
         assign inv_eff[g] = inv_q[g] && !DICR_CD_MASK[g];
         assign cond[g] = forced_lvl[g] ^ inv_eff[g];
      end
   endgenerate
   assign norm_word = {cond, cond & sfe_q[15:0]};

   // Source decode; unused codes give constant 0, or 1 when inverted
   function automatic logic src_sel(input logic [7:0] code, input logic [15:0] c,
                                    input logic [6:0] aux);
      logic base;
      base = 1'b0;
      if (code[6:0] >= DICR_SRC_IN1[6:0] && code[6:0] <= DICR_SRC_IN16[6:0]) begin
         base = c[code[3:0] - 4'h1];
      end else if (code[6:0] >= DICR_SRC_HALLU[6:0] && code[6:0] <= DICR_SRC_USB[6:0]) begin
         base = aux[code[2:0] - 3'h1];
      end
      src_sel = base ^ code[7];
   endfunction

   generate
      for (g = 0; g < 32; g++) begin : g_route
         assign route_word[g] = src_sel(tbl_q[g], cond, sync_q[22:16]);
      end
   endgenerate

   // Summary register: normal composition or the routing table
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sum_q <= DICR_RST_WORD;
      end else if (mode_q == DICR_ROUTED) begin
         sum_q <= route_word;
      end else begin
         sum_q <= norm_word;
      end
   end

   // ====================================================================
   // Outputs
   // Summary word and the special functions read from its low bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         input_summary_word <= DICR_RST_WORD;
         neg_limit <= 1'b0;
         pos_limit <= 1'b0;
         home_sw <= 1'b0;
      end else begin
         input_summary_word <= sum_q;
         neg_limit <= sum_q[DICR_BIT_NLIM];
         pos_limit <= sum_q[DICR_BIT_PLIM];
         home_sw <= sum_q[DICR_BIT_HOME];
      end
   end

   // Release taken from the summary, so a routed source also gates motion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         interlock_fault <= 1'b0;
      end else begin
         interlock_fault <= sfe_q[DICR_BIT_ILCK] && !sum_q[DICR_BIT_ILCK];
      end
   end

   // Clock and direction levels for the step interface, never inverted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cd_level <= 16'h0000;
      end else begin
         cd_level <= raw_q[15:0] & DICR_CD_MASK;
      end
   end

   // Input stage settings
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         threshold_24v <= 1'b0;
         pair_differential <= 1'b0;
         neg_input_en <= 16'h0000;
      end else begin
         threshold_24v <= thr_q[0];
         pair_differential <= pair_q[0];
         neg_input_en <= pair_q[0] ? DICR_CAP_MASK : 16'h0000;
      end
   end

   // ====================================================================
   // APB read path, zero wait states
   logic [31:0] rd_d;
   always_comb begin
      rd_d = 32'h0000_0000;
      case (paddr)
         DICR_OFS_SFE: rd_d = sfe_q;
         DICR_OFS_INV: rd_d = inv_q;
         DICR_OFS_FEN: rd_d = fen_q;
         DICR_OFS_FVAL: rd_d = fval_q;
         DICR_OFS_RAW: rd_d = raw_q;
         DICR_OFS_THR: rd_d = thr_q;
         DICR_OFS_PAIR: rd_d = pair_q;
         DICR_OFS_REN: rd_d = ren_q;
         DICR_OFS_SUM: rd_d = sum_q;
         DICR_OFS_STAT: rd_d = {30'h0, mode_q};
         default: begin
            if (paddr >= DICR_OFS_TBL) begin
               rd_d = {24'h0, tbl_q[paddr[6:2]]};
            end
         end
      endcase
   end

   // Read data is captured in the setup cycle and held until the next read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_d;
      end
   end

   // Every transfer is answered in its first access cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // Unmapped or unaligned addresses are refused; such writes change nothing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && !addr_ok(paddr);
      end
   end
   logic unused_rd;
   assign unused_rd = rd_en;
endmodule
`default_nettype wire

// ### testbench/dicr_src_model.sv
// Switches and signal sources that feed the inputs
`timescale 1ns/100ps
`default_nettype none
module dicr_src_model (
   // Clock
   input wire logic clk,
   // Source levels
   output var logic [15:0] pin_in,
   output var logic [2:0] hall_in,
   output var logic [2:0] enc_in,
   output var logic usb_power_in
);
   initial begin
      pin_in = 16'h0000;
      hall_in = 3'h0;
      enc_in = 3'h0;
      usb_power_in = 1'b0;
   end
   // Levels change after an edge and stay for many sample periods
   task automatic set(input logic [15:0] p, input logic [2:0] h, input logic [2:0] e,
      input logic u);
      @(posedge clk);
      pin_in <= p;
      hall_in <= h;
      enc_in <= e;
      usb_power_in <= u;
   endtask
endmodule
`default_nettype wire

// ### testbench/dicr_top_asserts.sv
// Port checks of the digital input conditioning router
`timescale 1ns/100ps
`default_nettype none
module dicr_top_asserts #(
   parameter int unsigned TICK_CYC = dicr_pkg::DICR_TICK_CYC
) (
   // Clock, reset and APB
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Results
   input wire logic [31:0] input_summary_word,
   input wire logic neg_limit,
   input wire logic pos_limit,
   input wire logic home_sw,
   input wire logic interlock_fault,
   input wire logic threshold_24v,
   input wire logic pair_differential,
   input wire logic [15:0] neg_input_en
);
   import dicr_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Write-tracked copies of the interlock enable and the pair mode bit
   logic ilck_en_q, ilck_en_d1, pair_en_q, pair_en_d1;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ilck_en_q <= 1'b0;
         pair_en_q <= 1'b0;
      end else if (psel && penable && pwrite) begin
         if (paddr == DICR_OFS_SFE) begin
            ilck_en_q <= pwdata[DICR_BIT_ILCK];
         end
         if (paddr == DICR_OFS_PAIR) begin
            pair_en_q <= pwdata[0];
         end
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ilck_en_d1 <= 1'b0;
         pair_en_d1 <= 1'b0;
      end else begin
         ilck_en_d1 <= ilck_en_q;
         pair_en_d1 <= pair_en_q;
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_thr_write;
      psel && penable && pwrite && paddr == DICR_OFS_THR;
   endsequence
   sequence s_low_steady;
      $stable(input_summary_word[3:0]) [*2];
   endsequence
   AST_READY: assert property (s_setup |=> pready)
      else $error("no pready after setup");
   AST_READY_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   AST_UNMAPPED: assert property (psel && !penable && paddr > DICR_OFS_STAT
      && paddr < DICR_OFS_TBL |=> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access accepted");
   AST_MAPPED: assert property (psel && !penable && !pwrite && paddr[1:0] == 2'b00
      && paddr <= DICR_OFS_STAT |=> !pslverr)
      else $error("mapped read refused");
   AST_RANGE: assert property (s_thr_write |=> ##1 threshold_24v == $past(pwdata[0], 2))
      else $error("range bit not taken");
   AST_PAIR: assert property (pair_differential == pair_en_d1
      && neg_input_en == {10'h000, {3{pair_en_d1}}, 3'h0})
      else $error("negative inputs wrong");
   AST_ILCK: assert property (interlock_fault == (ilck_en_d1 && !input_summary_word[3]))
      else $error("interlock fault differs from enable and release bit");
   AST_SPECIAL: assert property (s_low_steady
      |-> {home_sw, pos_limit, neg_limit} == input_summary_word[2:0])
      else $error("special outputs differ from summary");
   AST_FAULT: assert property (s_low_steady ##0 input_summary_word[3] |-> !interlock_fault)
      else $error("fault while release bit set");
   AST_RDHOLD: assert property (pready ##1 !psel |-> $stable(prdata))
      else $error("read data not held");
endmodule
bind dicr_top dicr_top_asserts #(.TICK_CYC(TICK_CYC)) u_chk (.clk(clk), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_summary_word(input_summary_word),
   .neg_limit(neg_limit), .pos_limit(pos_limit), .home_sw(home_sw),
   .interlock_fault(interlock_fault), .threshold_24v(threshold_24v),
   .pair_differential(pair_differential), .neg_input_en(neg_input_en));
`default_nettype wire

// ### testbench/dicr_top_test.sv
// Self-checking testbench of the digital input conditioning router
`timescale 1ns/100ps
`default_nettype none
module dicr_top_test;
   import dicr_pkg::*;
   localparam int unsigned TICK = 10;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, isw, rd;
   logic pready, pslverr, nlim, plim, home, ilf, thr, pdif, usb;
   logic [15:0] pins, cdl, nie, sfe, inv, fen, fval;
   logic [2:0] hall, enc;
   logic [7:0] codes [16] = '{8'h00, 8'h80, 8'h01, 8'h90, 8'h0C, 8'h41, 8'h43, 8'hC2,
      8'h44, 8'h46, 8'hC5, 8'h47, 8'hC7, 8'h20, 8'hA0, 8'h10};
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   dicr_top #(.TICK_CYC(TICK)) uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pins), .hall_in(hall), .enc_in(enc), .usb_power_in(usb),
      .input_summary_word(isw), .cd_level(cdl), .neg_limit(nlim), .pos_limit(plim),
      .home_sw(home), .interlock_fault(ilf), .threshold_24v(thr), .pair_differential(pdif),
      .neg_input_en(nie));
   dicr_src_model src (.clk(clk), .pin_in(pins), .hall_in(hall), .enc_in(enc),
      .usb_power_in(usb));
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures = failures + 1;
         end_sim();
      end
   end
   // ==========================================
   // Bus and check tasks
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cfg(input logic [15:0] s, input logic [15:0] i, input logic [15:0] f,
      input logic [15:0] v);
      {sfe, inv, fen, fval} = {s, i, f, v};
      xfer(1'b1, DICR_OFS_SFE, {16'h0, s});
      xfer(1'b1, DICR_OFS_INV, {16'h0, i});
      xfer(1'b1, DICR_OFS_FEN, {16'h0, f});
      xfer(1'b1, DICR_OFS_FVAL, {16'h0, v});
      xfer(1'b0, DICR_OFS_INV, 32'h0);
      chk("invert readback", {16'h0, i}, rd);
   endtask
   task automatic chk_sum(input string n);
      logic [15:0] c;
      repeat (2 * TICK + 10) @(posedge clk);
      c = ((fen & fval) | (~fen & pins)) ^ (inv & ~DICR_CD_MASK);
      chk(n, {c, c & sfe}, isw);
      chk("interlock fault", {31'h0, sfe[3] & ~c[3]}, {31'h0, ilf});
      chk("clock direction", {30'h0, pins[5:4]}, {30'h0, cdl[5:4]});
      $display("test %s done", n);
   endtask
   function automatic logic src_val(input logic [7:0] k);
      logic v;
      v = 1'b0;
      if (k[6:0] >= 7'h01 && k[6:0] <= 7'h10) v = pins[4'(k[6:0] - 7'h01)];
      if (k[6:0] >= 7'h41 && k[6:0] <= 7'h43) v = hall[k[1:0] - 2'h1];
      if (k[6:0] >= 7'h44 && k[6:0] <= 7'h46) v = enc[k[1:0]];
      if (k[6:0] == 7'h47) v = usb;
      return v ^ k[7];
   endfunction
   task automatic end_sim();
      $display("counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 0; a <= 9; a++) begin
         xfer(1'b0, 8'(4 * a), 32'h0);
         chk("reset value", DICR_RST_WORD, rd);
      end
      xfer(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      $display("test registers done");
      cfg(16'h0000, 16'h0000, 16'h0000, 16'h0000);
      src.set(16'h0001, 3'h0, 3'h0, 1'b0);
      chk_sum("level only");
      cfg(16'h000F, 16'h0000, 16'h0000, 16'h0000);
      chk_sum("limits enabled");
      chk("negative limit", 32'h1, {31'h0, nlim});
      cfg(16'h000F, 16'h0031, 16'h0000, 16'h0000);
      src.set(16'h0028, 3'h0, 3'h0, 1'b0);
      chk_sum("invert");
      cfg(16'h000F, 16'h0001, 16'h0006, 16'h000C);
      chk_sum("force");
      xfer(1'b1, DICR_OFS_RAW, 32'hFFFF);
      xfer(1'b0, DICR_OFS_RAW, 32'h0);
      chk("raw value", {16'h0, pins}, rd);
      xfer(1'b1, DICR_OFS_THR, 32'h1);
      xfer(1'b1, DICR_OFS_PAIR, 32'h1);
      repeat (2) @(posedge clk);
      chk("pair mode", 32'h0038, {16'h0, nie});
      chk("differential", 32'h1, {31'h0, pdif});
      chk("range select", 32'h1, {31'h0, thr});
      $display("test input stage done");
      cfg(16'hFFFF, 16'h0000, 16'h0000, 16'h0000);
      src.set(16'h0A52, 3'b101, 3'b011, 1'b1);
      chk_sum("before routing");
      xfer(1'b1, DICR_OFS_REN, 32'h1);
      chk_sum("routing preload");
      xfer(1'b0, 8'hC0, 32'h0);
      chk("entry bit 16", 32'h01, rd);
      xfer(1'b0, DICR_OFS_STAT, 32'h0);
      chk("routed mode", 32'h3, rd);
      for (int k = 0; k < 16; k++) begin
         xfer(1'b1, 8'hC0, {24'h0, codes[k]});
         repeat (2 * TICK + 10) @(posedge clk);
         chk("routed bit 16", {31'h0, src_val(codes[k])}, {31'h0, isw[16]});
      end
      xfer(1'b1, 8'h8C, {24'h0, DICR_SRC_INV});
      repeat (2 * TICK + 10) @(posedge clk);
      chk("interlock released", 32'h0, {31'h0, ilf});
      xfer(1'b1, 8'h8C, {24'h0, DICR_SRC_ZERO});
      repeat (2 * TICK + 10) @(posedge clk);
      chk("routed interlock", 32'h1, {31'h0, ilf});
      $display("test routing done");
      end_sim();
   end
endmodule
`default_nettype wire
